// ### verif/cacc_host_model.sv
`timescale 1ns/1ps
// Host on the shared bus; moves its pins only at falling system clock edges.
module cacc_host_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic bit_clk,
    output logic data_pull,
    output logic select_n
);
    // The bus idles with the clock high, data released and select high.
    initial begin
        bit_clk = 1'b1;
        data_pull = 1'b0;
        select_n = 1'b1;
    end
    // A quarter of a bit; the bit period is eight system clocks.
    task automatic q();
        repeat (2) @(negedge sys_clk);
    endtask
    // Data falls while the clock is high.
    task automatic start();
        data_pull = 1'b1;
        q();
        q();
    endtask
    // Data rises while the clock is high, then the bus stands still.
    task automatic stop();
        bit_clk = 1'b0;
        q();
        data_pull = 1'b1;
        q();
        bit_clk = 1'b1;
        q();
        data_pull = 1'b0;
        q();
    endtask
    // MSB first; data moves only while the clock is low.
    task automatic put_byte(input logic [7:0] b, input logic with_ack,
                            output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_clk = 1'b0;
            q();
            data_pull = ~b[i];
            q();
            bit_clk = 1'b1;
            q();
            q();
        end
        ack = 1'b0;
        // The acknowledge slot exists on the two-wire bus only.
        if (with_ack) begin
            bit_clk = 1'b0;
            q();
            data_pull = 1'b0;
            q();
            bit_clk = 1'b1;
            q();
            q();
            ack = ~sda_line;
        end
    endtask
    // Sample each bit late in the high phase, then answer ack or nack.
    task automatic get_byte(output logic [7:0] d, input logic ack);
        for (int i = 0; i < 8; i++) begin
            bit_clk = 1'b0;
            q();
            data_pull = 1'b0;
            q();
            bit_clk = 1'b1;
            q();
            q();
            d = {d[6:0], sda_line};
        end
        bit_clk = 1'b0;
        q();
        data_pull = ack;
        q();
        bit_clk = 1'b1;
        q();
        q();
    endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
    import cacc_pkg::*;
    logic sys_clk, rst, strap, sda_line, ack, sda_out, sda_oe, chain;
    logic [7:0] ext_rd_data, d;
    logic [6:0] register_pointer;
    logic ext_wr_strobe;
    cacc_wr_t ext_wr;
    cacc_wr_t wr_q[$];
    int errors, n_compared;
    wire logic scl, pull, sel_n;
    // Open-drain data line with a pull-up; either side may pull it low.
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~pull;
    cacc_host_model cacc_host_model_i (.sys_clk(sys_clk),
        .sda_line(sda_line), .bit_clk(scl), .data_pull(pull),
        .select_n(sel_n));
    cacc_control_port cacc_control_port_i (.sys_clk(sys_clk), .rst(rst),
        .serial_bit_clock(scl), .sda_mosi_in(sda_line),
        .chip_select_n(sel_n), .address_strap_pin(strap),
        .ext_rd_data(ext_rd_data), .sda_out(sda_out), .sda_oe(sda_oe),
        .chain_enable_out(chain), .register_pointer(register_pointer),
        .ext_wr_strobe(ext_wr_strobe), .ext_wr(ext_wr));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Outside registers answer with the pointer and collect writes.
    always @(negedge sys_clk) ext_rd_data <= {1'b1, register_pointer};
    always @(posedge sys_clk) begin
        if (ext_wr_strobe === 1'b1) begin
            wr_q.push_back(ext_wr);
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Reset for four cycles; the chain output must be low at their end.
    task automatic do_reset(input logic s);
        @(negedge sys_clk);
        rst = 1'b1;
        strap = s;
        repeat (4) @(negedge sys_clk);
        check(chain, 1'b0);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic put(input logic [7:0] b, input logic e, input logic i2c);
        cacc_host_model_i.put_byte(b, i2c, ack);
        if (i2c) check(ack, e);
    endtask
    // Two-wire write; a refused address ends the frame at once.
    task automatic wr(input logic [7:0] a, p, v, input logic e);
        cacc_host_model_i.start();
        put(a, e, 1'b1);
        if (e) put(p, 1'b1, 1'b1);
        if (e) put(v, 1'b1, 1'b1);
        cacc_host_model_i.stop();
    endtask
    // Aborted write sets the pointer, then a read with a final nack.
    task automatic rd(input logic [7:0] a, p, input logic e,
                      input logic [7:0] x);
        cacc_host_model_i.start();
        put(a, 1'b1, 1'b1);
        put(p, 1'b1, 1'b1);
        cacc_host_model_i.stop();
        cacc_host_model_i.start();
        put(a | 8'h01, e, 1'b1);
        if (e) cacc_host_model_i.get_byte(d, 1'b0);
        cacc_host_model_i.stop();
        if (e) check(d, x);
    endtask
    // Outside write arrives within a bounded wait.
    task automatic expect_wr(input logic [6:0] a, input logic [7:0] v);
        for (int i = 0; i < 40 && wr_q.size() == 0; i++) @(negedge sys_clk);
        if (wr_q.size() == 0) begin
            check(16'hdead, {1'b0, a, v});
            give_verdict();
        end else begin
            check(wr_q.pop_front(), {1'b0, a, v});
        end
    endtask
    task automatic sc_defaults();
        rd(8'h80, 8'h1b, 1'b1, CACC_ADDR_RST);
        rd(8'h80, 8'h19, 1'b1, CACC_ADDR_RST);
    endtask
    task automatic sc_groups();
        wr(8'h80, 8'h1a, 8'h21, 1'b1);
        wr(8'h80, 8'h19, 8'ha0, 1'b1);
        wr(8'h20, 8'h05, 8'h5a, 1'b1);
        expect_wr(7'h05, 8'h5a);
        check(register_pointer, 7'h05);
        rd(8'h20, 8'h05, 1'b0, 8'h00);
        wr(8'ha0, 8'h05, 8'h11, 1'b0);
        check(wr_q.size(), 16'h0);
    endtask
    // Configure this device, then release the next one in the chain.
    task automatic sc_chain();
        check(chain, 1'b0);
        wr(8'h80, 8'h1b, 8'h61, 1'b1);
        repeat (4) @(negedge sys_clk);
        check(chain, 1'b1);
        wr(8'h80, 8'h1b, 8'h00, 1'b0);
        rd(8'h60, 8'h1b, 1'b1, 8'h61);
        rd(8'h60, 8'h85, 1'b1, 8'h85);
        check(register_pointer, 7'h06);
    endtask
    task automatic sc_rereset();
        do_reset(1'b1);
        rd(8'h82, 8'h1a, 1'b1, 8'h82);
        rd(8'h82, 8'h1b, 1'b1, 8'h82);
    endtask
    // SPI frames: select low, bytes, select high.
    task automatic spi(input logic [23:0] f, input int n);
        cacc_host_model_i.select_n = 1'b0;
        cacc_host_model_i.q();
        for (int i = 0; i < n; i++) put(f[23-8*i -: 8], 1'b0, 1'b0);
        cacc_host_model_i.select_n = 1'b1;
        cacc_host_model_i.q();
    endtask
    task automatic sc_spi();
        do_reset(1'b0);
        spi({8'h80, 8'h85, 8'ha5}, 3);
        expect_wr(7'h05, 8'ha5);
        check(register_pointer, 7'h06);
        spi({8'h81, 8'h07, 8'h11}, 3);
        spi({8'h80, 8'h1b, 8'h23}, 3);
        repeat (8) @(negedge sys_clk);
        check(wr_q.size(), 16'h0);
        check(chain, 1'b1);
    endtask
    // Any hang ends the run as a mismatch.
    initial begin
        #1000000;
        errors++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        strap = 1'b0;
        errors = 0;
        n_compared = 0;
        do_reset(1'b0);
        sc_defaults();
        sc_groups();
        sc_chain();
        sc_rereset();
        sc_spi();
        give_verdict();
    end
endmodule

// ### verilog/cacc_control_port.sv
`timescale 1ns/1ps
// Contract
// - Three addresses: individual, two groups, own registers.
// - Individual address allows reads and writes.
// - Group addresses write only; group reads unanswered.
// - Reset loads default into all three addresses.
// - Address registers writable; match uses new value.
// - Every reset restores default addresses.
// - Group address matches only with enable bit.
// - Chain enable low in reset, high once enabled.
// - One write sets address and chain enable.
// - Shared group address writes reach all holders.
// - Two-wire unmatched read ignored until stop, start.
// - SPI read frame ignored until select cycles.
// - SPI default address is 1000000b; a high strap still sets bit 1 in SPI.
// - Pointer top bit selects auto increment.
module cacc_control_port
    import cacc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_bit_clock,
    input wire logic sda_mosi_in,
    input wire logic chip_select_n,
    input wire logic address_strap_pin,
    input wire logic [7:0] ext_rd_data,
    output logic sda_out,
    output logic sda_oe,
    output logic chain_enable_out,
    output logic [6:0] register_pointer,
    output logic ext_wr_strobe,
    output cacc_wr_t ext_wr
);
    // Two-stage synchroniser and an edge history stage for all pins.
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [3:0] pin_prev_reg;
    // Frame engine state.
    cacc_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic autoinc_reg;
    logic rw_reg;
    logic spi_mode_reg;
    logic strap_load_reg;
    // The three chip address registers, address in 7:1, enable in 0.
    logic [7:0] ind_addr_reg;
    logic [7:0] grp1_addr_reg;
    logic [7:0] grp2_addr_reg;
    logic [6:0] ptr_reg;

    // True when an address register holds this address and, where need_en is set, is enabled.
    function automatic logic addr_hit(input logic [7:0] r,
                                      input logic [6:0] a,
                                      input logic need_en);
        addr_hit = (r[7:1] == a) && (r[CACC_EN_BIT] || !need_en);
    endfunction

    // Edges seen by the system clock on synchronised pins.
    wire clk_s = pin_sync_reg[CACC_PIN_CLK];
    wire clk_rise = clk_s && !pin_prev_reg[CACC_PIN_CLK];
    wire clk_fall = !clk_s && pin_prev_reg[CACC_PIN_CLK];
    wire dat_s = pin_sync_reg[CACC_PIN_DAT];
    wire dat_fall = !dat_s && pin_prev_reg[CACC_PIN_DAT];
    wire dat_rise = dat_s && !pin_prev_reg[CACC_PIN_DAT];
    wire cs_fall = !pin_sync_reg[CACC_PIN_CS] && pin_prev_reg[CACC_PIN_CS];
    wire cs_rise = pin_sync_reg[CACC_PIN_CS] && !pin_prev_reg[CACC_PIN_CS];
    wire i2c_start = !spi_mode_reg && clk_s && dat_fall;
    wire i2c_stop = !spi_mode_reg && clk_s && dat_rise;
    wire frame_begin = i2c_start || cs_fall;
    wire frame_end = i2c_stop || (spi_mode_reg && cs_rise);
    // A byte is complete on the 8th SPI rise or the two-wire fall after it.
    wire byte_done = spi_mode_reg ? (clk_rise && bit_cnt_reg == CACC_LAST_BIT)
                                  : (clk_fall && bit_cnt_reg == CACC_ACK_BIT);
    wire ack_end = !spi_mode_reg && clk_fall && bit_cnt_reg == CACC_ACK_END;
    // Completed byte: in SPI the last bit is still on the data pin.
    wire [7:0] rx_byte = spi_mode_reg ? {shift_reg[6:0], dat_s} : shift_reg;
    // Parallel comparison of the first byte's seven address bits.
    wire [6:0] rx_addr = rx_byte[7:1];
    wire rx_read = rx_byte[0];
    wire hit_ind = addr_hit(ind_addr_reg, rx_addr, 1'b0);
    wire hit_grp = addr_hit(grp1_addr_reg, rx_addr, 1'b1) ||
                   addr_hit(grp2_addr_reg, rx_addr, 1'b1);
    wire addr_done = byte_done && state_reg == CACC_ADDR;
    wire wdata_done = byte_done && state_reg == CACC_WDATA;
    wire rdata_done = byte_done && state_reg == CACC_RDATA;
    // Only the individual address may read, and only over two wires.
    wire read_ok = rx_read && hit_ind && !spi_mode_reg;
    wire write_ok = !rx_read && (hit_ind || hit_grp);
    wire wr_ind = wdata_done && ptr_reg == CACC_IND_OFS;
    wire wr_grp1 = wdata_done && ptr_reg == CACC_GRP1_OFS;
    wire wr_grp2 = wdata_done && ptr_reg == CACC_GRP2_OFS;
    wire ptr_step = (wdata_done || rdata_done) && autoinc_reg;
    wire [7:0] rd_mux = (ptr_reg == CACC_IND_OFS) ? ind_addr_reg :
                        (ptr_reg == CACC_GRP1_OFS) ? grp1_addr_reg :
                        (ptr_reg == CACC_GRP2_OFS) ? grp2_addr_reg :
                        ext_rd_data;
    wire bit_out = tx_reg[CACC_LAST_BIT[2:0] - bit_cnt_reg[2:0]];

    // Pins cross into the system clock through two flip-flops.
    always_ff @(posedge sys_clk) begin
        pin_meta_reg <= {address_strap_pin, chip_select_n, sda_mosi_in,
                         serial_bit_clock};
        pin_sync_reg <= pin_meta_reg;
        pin_prev_reg <= pin_sync_reg;
    end

    // Frame state: start or select fall opens, stop or select rise closes.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= CACC_IDLE;
        end else if (frame_begin) begin
            state_reg <= CACC_ADDR;
        end else if (frame_end) begin
            state_reg <= CACC_IDLE;
        end else if (addr_done) begin
            // Unmatched or forbidden requests sit out the frame.
            state_reg <= read_ok ? CACC_RDATA :
                         write_ok ? CACC_PTR : CACC_IGNORE;
        end else if (byte_done && state_reg == CACC_PTR) begin
            state_reg <= CACC_WDATA;
        end else if (clk_rise && state_reg == CACC_RDATA &&
                     bit_cnt_reg == CACC_ACK_BIT && dat_s) begin
            // A master not-acknowledge ends the read.
            state_reg <= CACC_IGNORE;
        end
    end

    // Bit counter and receive shifter, sampled on the bit clock rise.
    always_ff @(posedge sys_clk) begin
        if (rst || frame_begin) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
        end else if (byte_done && spi_mode_reg) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= {shift_reg[6:0], dat_s};
        end else if (ack_end) begin
            bit_cnt_reg <= 4'h0;
        end else if (clk_rise && state_reg != CACC_IDLE) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg < CACC_ACK_BIT) begin
                shift_reg <= {shift_reg[6:0], dat_s};
            end
        end
    end

    // Mode selection: a select fall after reset chooses SPI.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            spi_mode_reg <= 1'b0;
        end else if (cs_fall) begin
            spi_mode_reg <= 1'b1;
        end
    end

    // Pointer byte and auto increment after each data byte.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ptr_reg <= 7'h00;
            autoinc_reg <= 1'b0;
        end else if (byte_done && state_reg == CACC_PTR) begin
            ptr_reg <= rx_byte[6:0];
            autoinc_reg <= rx_byte[7];
        end else if (ptr_step) begin
            ptr_reg <= ptr_reg + 7'h01;
        end
    end

    // Read byte loaded at the end of each acknowledge slot.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_reg <= 8'h00;
        end else if (ack_end) begin
            tx_reg <= rd_mux;
        end
    end

    // Two-wire data pin: pull low for acknowledge or a zero read bit.
    always_ff @(posedge sys_clk) begin
        if (rst || frame_begin || frame_end) begin
            sda_oe <= 1'b0;
        end else if (byte_done && !spi_mode_reg) begin
            sda_oe <= (state_reg == CACC_ADDR) ? (read_ok || write_ok) :
                      (state_reg != CACC_RDATA && state_reg != CACC_IGNORE);
        end else if (ack_end) begin
            sda_oe <= (state_reg == CACC_RDATA) && !rd_mux[7];
        end else if (clk_fall && state_reg == CACC_RDATA &&
                     bit_cnt_reg < CACC_ACK_BIT) begin
            sda_oe <= !bit_out;
        end
    end
    assign sda_out = 1'b0;

    // Strap is taken in the first cycle after reset release.
    always_ff @(posedge sys_clk) begin
        strap_load_reg <= rst;
    end
    wire strap_or = strap_load_reg && !spi_mode_reg &&
                    pin_sync_reg[CACC_PIN_STRAP];
    wire [7:0] strap_bits = 8'(strap_or) << CACC_STRAP_BIT;

    // Chip address registers: default on reset, serial writes after.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ind_addr_reg <= CACC_ADDR_RST;
            grp1_addr_reg <= CACC_ADDR_RST;
            grp2_addr_reg <= CACC_ADDR_RST;
        end else begin
            ind_addr_reg <= wr_ind ? rx_byte :
                            (ind_addr_reg | strap_bits);
            grp1_addr_reg <= wr_grp1 ? rx_byte :
                             (grp1_addr_reg | strap_bits);
            grp2_addr_reg <= wr_grp2 ? rx_byte :
                             (grp2_addr_reg | strap_bits);
        end
    end

    // Writes to any other pointer go out to the outside registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_wr_strobe <= 1'b0;
            ext_wr <= '0;
        end else begin
            ext_wr_strobe <= wdata_done && !wr_ind && !wr_grp1 && !wr_grp2;
            if (wdata_done) begin
                ext_wr <= '{addr: ptr_reg, data: rx_byte};
            end
        end
    end
    assign register_pointer = ptr_reg;

    // Chain enable follows the individual register's enable bit.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chain_enable_out <= 1'b0;
        end else begin
            chain_enable_out <= ind_addr_reg[CACC_EN_BIT];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Write of the individual register with the enable-next flag set.
    sequence s_ind_enable_write;
        wr_ind && rx_byte[CACC_EN_BIT];
    endsequence
    // Read request that names no individual address, frame still open.
    sequence s_bad_read;
        addr_done && rx_read && !hit_ind && !frame_begin && !frame_end;
    endsequence

    a_chain_after_write: assert property (s_ind_enable_write |-> ##2
        chain_enable_out) else $error("chain enable not raised");
    a_chain_in_reset: assert property (disable iff (1'b0) rst |=> ##1
        !chain_enable_out) else $error("chain enable high in reset");
    a_default_address: assert property (disable iff (1'b0) rst |=>
        ind_addr_reg[7:1] == CACC_ADDR_RST[7:1] && !grp1_addr_reg[0])
        else $error("address not default after reset");
    a_bad_read_ignored: assert property (s_bad_read |=>
        state_reg == CACC_IGNORE)
        else $error("unmatched read not ignored");
    a_group_disabled: assert property (addr_done && !hit_ind &&
        rx_addr == grp2_addr_reg[7:1] && !grp2_addr_reg[CACC_EN_BIT] &&
        rx_addr != grp1_addr_reg[7:1] && !frame_end && !frame_begin
        |=> state_reg == CACC_IGNORE)
        else $error("disabled group matched");
    a_spi_read_ignored: assert property (spi_mode_reg && addr_done &&
        rx_read && !frame_end && !frame_begin |=> state_reg == CACC_IGNORE)
        else $error("spi read accepted");
    a_ignore_holds: assert property (state_reg == CACC_IGNORE &&
        !frame_begin && !frame_end |=> state_reg == CACC_IGNORE)
        else $error("ignore left early");
    a_pointer_step: assert property (wdata_done && autoinc_reg |=>
        ptr_reg == $past(ptr_reg) + 7'h01)
        else $error("pointer did not advance");
    a_pointer_hold: assert property (wdata_done && !autoinc_reg |=>
        $stable(ptr_reg)) else $error("pointer moved");
    a_address_write: assert property (wr_ind |=> ind_addr_reg ==
        $past(rx_byte)) else $error("address write lost");
endmodule

// ### verilog/cacc_pkg.sv
package cacc_pkg;
    // Register pointer values of the three chip address registers.
    localparam logic [6:0] CACC_GRP2_OFS = 7'h19;
    localparam logic [6:0] CACC_GRP1_OFS = 7'h1a;
    localparam logic [6:0] CACC_IND_OFS = 7'h1b;
    // Field positions inside an address register.
    localparam int CACC_EN_BIT = 0;
    localparam int CACC_STRAP_BIT = 1;
    // Address register value after reset: 1000000b in bits 7:1.
    localparam logic [7:0] CACC_ADDR_RST = 8'h80;
    // Bit count positions of a byte and of the two-wire acknowledge.
    localparam logic [3:0] CACC_LAST_BIT = 4'h7;
    localparam logic [3:0] CACC_ACK_BIT = 4'h8;
    localparam logic [3:0] CACC_ACK_END = 4'h9;
    // Pin bundle positions in the synchroniser.
    localparam int CACC_PIN_CLK = 0;
    localparam int CACC_PIN_DAT = 1;
    localparam int CACC_PIN_CS = 2;
    localparam int CACC_PIN_STRAP = 3;
    // Frame states.
    typedef enum logic [2:0] {
        CACC_IDLE, CACC_ADDR, CACC_PTR, CACC_WDATA, CACC_RDATA, CACC_IGNORE
    } cacc_state_t;
    // Register write handed to the registers outside this block.
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } cacc_wr_t;
endpackage
